// *** shared/otp_pkg.sv ***
package otp_pkg;
  // array geometry
  localparam int          ADDR_W      = 17;
  localparam int          DATA_W      = 8;
  localparam logic [16:0] ADDR_LAST   = 17'h07FFF;
  localparam logic [16:0] ADDR_ONE    = 17'h00001;
  localparam logic [1:0]  PAGE_LAST   = 2'h3;
  // timing at 40 MHz
  localparam int          CLK_HZ      = 40000000;
  localparam int          PULSE_NS    = 100000;
  localparam int          PULSE_CYC   = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int          SETUP_CYC   = 4;
  localparam logic [3:0]  MAX_TRIES   = 4'hA;
  localparam logic [12:0] CNT_ZERO    = 13'h0000;

  // pins driven toward the device
  typedef struct packed {
    logic        rst_n;
    logic        vpp_high;
    logic        vpp_on;
    logic        select_n;
    logic        read_strobe_n;
    logic        program_pulse_n;
    logic [16:0] addr;
  } otp_pins_t;

  // operation codes of the command port
  typedef enum logic [1:0] {
    OTP_OP_READ = 2'h0,
    OTP_OP_PAGE = 2'h1,
    OTP_OP_BYTE = 2'h2
  } otp_op_t;
endpackage : otp_pkg

// *** hdl/otp_prog.sv ***
`timescale 1ns/100ps
// What this block does
// - page latched then 0.1 ms program pulse
// - verify page by select, strobe low
// - byte write: select low, pulse low
// - retry pulse-verify, fail after ten tries
// - write only within 0000H to 7FFFH
// - normal supply, verify all, report result
// - read: reset low, normal supply, address
module otp_prog (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  // command port
  input  wire logic              start_i,
  input  wire otp_pkg::otp_op_t  op_i,
  input  wire logic [16:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   fail_o,
  output logic [7:0]             rdata_o,
  // device pins
  output otp_pkg::otp_pins_t     pins_o,
  input  wire logic [7:0]        data_i,
  output logic [7:0]             data_o,
  output logic                   data_oe_o
);
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_LATCH = 8'h02,
    ST_PULSE = 8'h04,
    ST_VFY   = 8'h08,
    ST_NORM  = 8'h10,
    ST_CHK   = 8'h20,
    ST_READ  = 8'h40,
    ST_DONE  = 8'h80
  } otp_st_t;

  otp_st_t            state_q;
  otp_pkg::otp_op_t   op_q;
  logic [16:0]        base_q;
  logic [31:0]        wdata_q;
  logic [1:0]         idx_q;
  logic [3:0]         tries_q;
  logic [12:0]        cnt_q;
  logic [7:0]         rdata_q;
  logic               fail_q;
  logic               done_q;
  logic               phase_q;
  logic [7:0]         cur_byte;
  logic               last_ent;
  logic               cnt_end;

  assign cur_byte = wdata_q[{idx_q, 3'h0} +: 8];
  assign last_ent = (op_q == otp_pkg::OTP_OP_BYTE) || (idx_q == otp_pkg::PAGE_LAST);
  assign cnt_end  = (cnt_q == otp_pkg::CNT_ZERO);

  // sequencer: strobes are held setup cycles each phase
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= otp_pkg::CNT_ZERO;
      idx_q   <= 2'h0;
      tries_q <= 4'h0;
      phase_q <= 1'b0;
    end else if (!cnt_end) begin
      cnt_q <= cnt_q - 13'h0001;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            idx_q   <= 2'h0;
            tries_q <= 4'h0;
            phase_q <= 1'b0;
            cnt_q   <= 13'(otp_pkg::SETUP_CYC);
            if (op_i == otp_pkg::OTP_OP_READ) state_q <= ST_READ;
            else if (op_i == otp_pkg::OTP_OP_PAGE) state_q <= ST_LATCH;
            else if (op_i == otp_pkg::OTP_OP_BYTE) begin
              // address and data settle with the falling pulse; device takes them at its rise
              state_q <= ST_PULSE;
              cnt_q   <= 13'(otp_pkg::PULSE_CYC - 1);
            end else begin
              state_q <= ST_DONE; // undefined code ends without touching the part
            end
          end
        end
        ST_LATCH: begin
          // strobe low then high per entry, next entry after release
          phase_q <= ~phase_q;
          cnt_q   <= 13'(otp_pkg::SETUP_CYC);
          if (phase_q) begin
            if (idx_q == otp_pkg::PAGE_LAST) begin
              idx_q   <= 2'h0;
              cnt_q   <= 13'(otp_pkg::PULSE_CYC - 1);
              state_q <= ST_PULSE;
            end else begin
              idx_q <= idx_q + 2'h1;
            end
          end
        end
        ST_PULSE: begin
          // phase 0 holds pulse low for the full width, phase 1 releases it
          // so the rise lands with the strobe still high
          phase_q <= ~phase_q;
          cnt_q   <= 13'(otp_pkg::SETUP_CYC);
          if (!phase_q) begin
            tries_q <= tries_q + 4'h1;
          end else begin
            state_q <= ST_VFY;
          end
        end
        ST_VFY: begin
          // compare every entry of the page; a miss re-pulses, or ends with fail once tries_q reaches MAX_TRIES
          cnt_q <= 13'(otp_pkg::SETUP_CYC);
          if (data_i != cur_byte) begin
            idx_q <= 2'h0;
            if (tries_q == otp_pkg::MAX_TRIES) state_q <= ST_DONE;
            else begin
              state_q <= ST_PULSE;
              cnt_q   <= 13'(otp_pkg::PULSE_CYC - 1);
            end
          end else if (last_ent) begin
            idx_q   <= 2'h0;
            state_q <= ST_NORM;
          end else begin
            idx_q <= idx_q + 2'h1;
          end
        end
        ST_NORM: begin
          cnt_q   <= 13'(otp_pkg::SETUP_CYC);
          state_q <= ST_CHK;
        end
        ST_CHK: begin
          // final check at normal supply
          cnt_q <= 13'(otp_pkg::SETUP_CYC);
          if (last_ent) state_q <= ST_DONE;
          else idx_q <= idx_q + 2'h1;
        end
        ST_READ: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // command capture; out-of-range writes are clipped to wrap inside the array
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_q    <= otp_pkg::OTP_OP_READ;
      base_q  <= 17'h00000;
      wdata_q <= 32'h00000000;
    end else if (state_q == ST_IDLE && start_i) begin
      op_q    <= op_i;
      base_q  <= addr_i & otp_pkg::ADDR_LAST;
      wdata_q <= wdata_i;
    end
  end

  // result registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
      fail_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= (state_q == ST_DONE) && cnt_end;
      if (state_q == ST_READ && cnt_end) rdata_q <= data_i;
      if (state_q == ST_IDLE && start_i) fail_q <= 1'b0;
      else if (state_q == ST_VFY && cnt_end && data_i != cur_byte
               && tries_q == otp_pkg::MAX_TRIES) fail_q <= 1'b1;
      else if (state_q == ST_CHK && cnt_end && data_i != cur_byte) fail_q <= 1'b1;
    end
  end

  // pin decode; device is in programming mode whenever busy
  always_comb begin
    pins_o                 = '0;
    pins_o.rst_n           = 1'b0;
    pins_o.vpp_on          = 1'b1;
    pins_o.vpp_high        = 1'b0;
    pins_o.select_n        = 1'b1; // standby while idle
    pins_o.read_strobe_n   = 1'b1; // device bus released
    pins_o.program_pulse_n = 1'b1; // no write unless pulsed
    pins_o.addr            = (base_q + {15'h0000, idx_q}) & otp_pkg::ADDR_LAST;
    data_oe_o              = 1'b0;
    data_o                 = cur_byte;
    unique case (state_q)
      ST_LATCH: begin
        pins_o.vpp_high      = 1'b1;
        pins_o.read_strobe_n = phase_q;
        data_oe_o            = 1'b1;
      end
      ST_PULSE: begin
        pins_o.vpp_high        = 1'b1;
        pins_o.select_n        = (op_q == otp_pkg::OTP_OP_PAGE);
        pins_o.program_pulse_n = phase_q;
        data_oe_o              = (op_q == otp_pkg::OTP_OP_BYTE);
      end
      ST_VFY: begin
        pins_o.vpp_high      = 1'b1;
        pins_o.select_n      = 1'b0;
        pins_o.read_strobe_n = 1'b0;
      end
      ST_CHK, ST_READ: begin
        pins_o.select_n      = 1'b0;
        pins_o.read_strobe_n = 1'b0;
      end
      default: ;
    endcase
  end

  assign busy_o  = (state_q != ST_IDLE);
  assign done_o  = done_q;
  assign fail_o  = fail_q;
  assign rdata_o = rdata_q;

  // checks
  chk_pulse_width: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(pins_o.program_pulse_n) |-> !pins_o.program_pulse_n [*8])
    else $error("program pulse too short");
  chk_bus_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pins_o.read_strobe_n |-> !data_oe_o || state_q == ST_LATCH)
    else $error("host drives bus during read");
  chk_no_contention: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_VFY || state_q == ST_CHK) |-> !data_oe_o)
    else $error("bus contention on verify");
  chk_tries_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tries_q <= otp_pkg::MAX_TRIES)
    else $error("too many attempts");
  chk_addr_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    pins_o.addr <= otp_pkg::ADDR_LAST)
    else $error("address beyond array");
  chk_reset_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy_o |-> !pins_o.rst_n)
    else $error("reset released while busy");
  chk_inhibit_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !busy_o |-> pins_o.program_pulse_n && pins_o.select_n)
    else $error("idle host writes");
  chk_latch_strobe: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_LATCH && !pins_o.read_strobe_n) |-> pins_o.select_n && data_oe_o)
    else $error("latch cycle malformed");
  chk_read_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_q == ST_READ && cnt_end) |-> ##[1:8] done_o)
    else $error("read never completes");

  cov_read:  cover property (@(posedge clk_i) state_q == ST_READ ##1 state_q == ST_DONE);
  cov_page:  cover property (@(posedge clk_i) state_q == ST_LATCH ##1 state_q == ST_PULSE);
  cov_retry: cover property (@(posedge clk_i) state_q == ST_VFY ##1 state_q == ST_PULSE);
  cov_fail:  cover property (@(posedge clk_i) $rose(fail_o));
endmodule : otp_prog

// *** dv/otp_dev_model.sv ***
`timescale 1ns/100ps
module otp_dev_model (
  // clock
  input  wire logic               clk_i,
  // pins from the programmer
  input  wire otp_pkg::otp_pins_t pins_i,
  input  wire logic [7:0]         host_i,
  input  wire logic               host_oe_i,
  input  wire logic [3:0]         need_i,
  // bus level and observations
  output logic [7:0]              bus_o,
  output logic [7:0]              pcnt_o,
  output logic [15:0]             plen_o,
  output logic                    bad_o
);
  logic [7:0]         mem_q [0:32767];
  logic [14:0]        la_q [0:3];
  logic [7:0]         ld_q [0:3];
  logic [1:0]         idx_q;
  logic [3:0]         try_q;
  logic [15:0]        run_q;
  logic [7:0]         last_q;
  otp_pkg::otp_pins_t prev_q;
  logic               dev_oe;

  // device drives only with select and strobe low, pulse high
  assign dev_oe = !pins_i.select_n && !pins_i.read_strobe_n && pins_i.program_pulse_n;
  // a released bus shows the inverse of its last level, never a held copy
  assign bus_o = host_oe_i ? host_i : dev_oe ? mem_q[pins_i.addr[14:0]] : ~last_q;

  // erased array and idle observers
  initial begin
    for (int i = 0; i < 32768; i++) mem_q[i] = 8'hFF;
    {idx_q, try_q, run_q, last_q, pcnt_o, plen_o, bad_o} = '0;
    prev_q = '1;
  end

  // mode decode sampled on the host clock; weak cells need need_i pulses
  always @(posedge clk_i) begin
    prev_q <= pins_i;
    last_q <= bus_o;
    run_q  <= pins_i.program_pulse_n ? 16'h0000 : run_q + 16'h0001;
    if (dev_oe && host_oe_i) bad_o <= 1'b1;
    if ((!pins_i.select_n || !pins_i.program_pulse_n) && (pins_i.rst_n || !pins_i.vpp_on))
      bad_o <= 1'b1;
    if (pins_i.select_n && prev_q.select_n && pins_i.program_pulse_n && pins_i.read_strobe_n
        && !prev_q.read_strobe_n) begin
      la_q[idx_q] <= prev_q.addr[14:0];
      ld_q[idx_q] <= last_q;
      idx_q       <= idx_q + 2'h1;
    end
    if (pins_i.program_pulse_n && !prev_q.program_pulse_n && pins_i.read_strobe_n) begin
      pcnt_o <= pcnt_o + 8'h01;
      plen_o <= run_q;
      try_q  <= try_q + 4'h1;
      if (try_q + 4'h1 >= need_i) begin
        try_q <= 4'h0;
        if (prev_q.select_n) for (int k = 0; k < 4; k++) mem_q[la_q[k]] <= ld_q[k];
        else mem_q[prev_q.addr[14:0]] <= last_q;
      end
    end
  end
endmodule : otp_dev_model

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  logic               clk_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               start_i = 1'b0;
  otp_pkg::otp_op_t   op_i = otp_pkg::OTP_OP_READ;
  logic [16:0]        addr_i = 17'h00000;
  logic [31:0]        wdata_i = 32'h00000000;
  logic               busy_o, done_o, fail_o, data_oe_o, bad;
  logic [7:0]         rdata_o, data_i, data_o, pcnt, cnt0;
  logic [15:0]        plen;
  logic [3:0]         need = 4'h1;
  otp_pkg::otp_pins_t pins_o;
  int                 miscompares = 0;
  int                 total_checks = 0;

  // free-running host clock
  always #12.5 clk_i = ~clk_i;

  otp_prog dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .fail_o(fail_o),
    .rdata_o(rdata_o), .pins_o(pins_o), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o));
  otp_dev_model dev (.clk_i(clk_i), .pins_i(pins_o), .host_i(data_o), .host_oe_i(data_oe_o),
    .need_i(need), .bus_o(data_i), .pcnt_o(pcnt), .plen_o(plen), .bad_o(bad));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one command, waiting for done under a bound
  task automatic run_cmd(input otp_pkg::otp_op_t op, input logic [16:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    cnt0 = pcnt;
    @(negedge clk_i);
    {op_i, addr_i, wdata_i, start_i} = {op, a, wd, 1'b1};
    @(negedge clk_i);
    start_i = 1'b0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (done_o !== 1'b1 && n < 50000);
    if (done_o !== 1'b1) begin
      check("done_o", done_o, 32'h1);
      print_verdict();
    end
  endtask : run_cmd

  task automatic t_read_erased;
    check("select_n idle", pins_o.select_n, 32'h1);
    check("data_oe idle", data_oe_o, 32'h0);
    run_cmd(otp_pkg::OTP_OP_READ, 17'h00123, 32'h0);
    check("rdata erased", rdata_o, 32'hFF);
  endtask : t_read_erased

  // address above the array must wrap into it
  task automatic t_byte_write;
    need = 4'h1;
    run_cmd(otp_pkg::OTP_OP_BYTE, 17'h18005, 32'h000000A5);
    check("fail byte", fail_o, 32'h0);
    check("pulses byte", pcnt - cnt0, 32'h1);
    check("pulse len byte", plen >= otp_pkg::PULSE_CYC, 32'h1);
    run_cmd(otp_pkg::OTP_OP_READ, 17'h00005, 32'h0);
    check("rdata byte", rdata_o, 32'hA5);
  endtask : t_byte_write

  // top page of the array, cells needing a second pulse
  task automatic t_page_write;
    need = 4'h2;
    run_cmd(otp_pkg::OTP_OP_PAGE, 17'h07FFC, 32'h3C5A9612);
    check("fail page", fail_o, 32'h0);
    check("pulses page", pcnt - cnt0, 32'h2);
    check("pulse len page", plen >= otp_pkg::PULSE_CYC, 32'h1);
    for (int k = 0; k < 4; k++) begin
      run_cmd(otp_pkg::OTP_OP_READ, 17'h07FFC + 17'(k), 32'h0);
      check("rdata page", rdata_o, (32'h3C5A9612 >> (8 * k)) & 32'hFF);
    end
  endtask : t_page_write

  // a cell that never takes: ten tries then give up
  task automatic t_retry_fail;
    need = 4'hB;
    run_cmd(otp_pkg::OTP_OP_BYTE, 17'h00100, 32'h0000005A);
    check("fail set", fail_o, 32'h1);
    check("pulses fail", pcnt - cnt0, 32'hA);
    run_cmd(otp_pkg::OTP_OP_READ, 17'h00100, 32'h0);
    check("fail cleared", fail_o, 32'h0);
    check("rdata unwritten", rdata_o, 32'hFF);
  endtask : t_retry_fail

  initial begin
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_read_erased();
    t_byte_write();
    t_page_write();
    t_retry_fail();
    check("busy after", busy_o, 32'h0);
    check("pin faults", bad, 32'h0);
    print_verdict();
  end
endmodule : tb_top
